//--- include/dbcrc_pkg.sv
// constants for the bus cycle and dynamic ram controller
//
// Summary of operation
// - 8MHz one-third clock from 24MHz divided by three
// - ram cycles need no waits except refresh
// - non-ram cycles get one, two or three waits
// - address latch strobe falls at start of first bus state
// - read and write strobes valid at second state
// - 256K bytes as two 128K banks
// - ram cycle needs A18, A19 low, memory status
// - address bits 1..16 split into row, column
// - row strobe two cycles, column follows by one
// - mux selects column one clock after row strobe activates
// - address bit 17 selects bank row strobe
// - column strobe lanes from bit 0 and enable
// - divide 8MHz by 128, refresh every 16us
// - grant refresh only when strobes idle
// - refresh counter drives address, mux disabled
// - refresh keeps mux high, column strobe gated
// - memory cycle during refresh waits, then proceeds
package dbcrc_pkg;
    // crystal divide
    localparam int unsigned XTAL_HZ        = 24_000_000;
    localparam int unsigned SYS_HZ         = 8_000_000;
    localparam int unsigned XTAL_DIV       = XTAL_HZ / SYS_HZ;
    localparam logic [1:0]  DIV_LAST       = 2'h2;
    // refresh timing
    localparam int unsigned REFRESH_US     = 16;
    localparam int unsigned REFRESH_DIV    = 128;
    localparam logic [6:0]  REFRESH_LAST   = 7'h7F;
    // strobe lengths in system cycles
    localparam logic [1:0]  ROW_CYCLES     = 2'h2;
    // wait jumper encodings
    localparam logic [1:0]  WAIT_ONE       = 2'h1;
    localparam logic [1:0]  WAIT_TWO       = 2'h2;
    localparam logic [1:0]  WAIT_THREE     = 2'h3;
    localparam logic [1:0]  WAIT_DEFAULT   = WAIT_TWO;
    // status codes, active low lines s2 s1 s0
    localparam logic [2:0]  ST_INTA        = 3'h0;
    localparam logic [2:0]  ST_IORD        = 3'h1;
    localparam logic [2:0]  ST_IOWR        = 3'h2;
    localparam logic [2:0]  ST_HALT        = 3'h3;
    localparam logic [2:0]  ST_CODE        = 3'h4;
    localparam logic [2:0]  ST_MRD         = 3'h5;
    localparam logic [2:0]  ST_MWR         = 3'h6;
    localparam logic [2:0]  ST_PASSIVE     = 3'h7;
    // address fields
    localparam int unsigned BANK_BIT       = 17;
    localparam logic [7:0]  REFRESH_RESET  = 8'h00;
    typedef enum logic [2:0] {ST_IDLE, ST_ROW, ST_BOTH, ST_COL, ST_DONE} dbcrc_mem_e;
endpackage : dbcrc_pkg

//--- hw/dbcrc_div.sv
// parameterised wrapping counter that emits a one-cycle tick
`timescale 1ns/1ps
module dbcrc_div
#(
    parameter int unsigned WIDTH = 2
)
(
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    // count control
    input  wire logic             en_in,
    input  wire logic [WIDTH-1:0] last_in,
    // outputs
    output logic      [WIDTH-1:0] count_out,
    output logic                  tick_out
);
    // --------------------------------------------------
    // counter
    // --------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            count_out <= '0;
        else if (en_in)
            count_out <= (count_out == last_in) ? '0 : count_out + 1'b1;
    end

    assign tick_out = en_in && (count_out == last_in);
endmodule : dbcrc_div

//--- hw/dbcrc_ctrl.sv
// bus cycle control, wait states, dram strobes and refresh
`timescale 1ns/1ps
module dbcrc_ctrl
    import dbcrc_pkg::*;
(
    // clock and reset, clk_in is the 24MHz reference
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // processor bus
    input  wire logic [19:0] cpu_addr_in,
    input  wire logic        upper_byte_enable_n,
    input  wire logic        cpu_status_bit0,
    input  wire logic        cpu_status_bit1,
    input  wire logic        cpu_status_bit2,
    // wait jumper
    input  wire logic [1:0]  wait_select_in,
    // system clock and bus outputs
    output logic             sys_clk_out,
    output logic             delayed_system_clock,
    output logic             ale_out,
    output logic             first_bus_state,
    output logic             second_bus_state,
    output logic             mem_rd_n_out,
    output logic             mem_wr_n_out,
    output logic             io_rd_n_out,
    output logic             io_wr_n_out,
    output logic             ready_out,
    // dram
    output logic [7:0]       dram_addr_out,
    output logic             row_strobe_lower_bank,
    output logic             row_strobe_upper_bank,
    output logic             col_strobe_high_n_out,
    output logic             col_strobe_low_n_out,
    output logic             mux_col_out,
    output logic             refresh_out
);
    // --------------------------------------------------
    // pin synchronisers
    // --------------------------------------------------
    logic [2:0]  st_s1_reg, st_s2_reg, st_s3_reg, st_reg;
    logic [19:0] a_s1_reg, a_s2_reg, a_s3_reg, a_reg;
    logic        bhe_s1_reg, bhe_s2_reg, bhe_s3_reg, bhe_reg;
    logic [1:0]  j_s1_reg, j_s2_reg, j_s3_reg, j_reg;

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            st_s1_reg  <= ST_PASSIVE;
            st_s2_reg  <= ST_PASSIVE;
            st_s3_reg  <= ST_PASSIVE;
            st_reg     <= ST_PASSIVE;
            a_s1_reg   <= '0;
            a_s2_reg   <= '0;
            a_s3_reg   <= '0;
            a_reg      <= '0;
            bhe_s1_reg <= 1'b1;
            bhe_s2_reg <= 1'b1;
            bhe_s3_reg <= 1'b1;
            bhe_reg    <= 1'b1;
            j_s1_reg   <= WAIT_DEFAULT;
            j_s2_reg   <= WAIT_DEFAULT;
            j_s3_reg   <= WAIT_DEFAULT;
            j_reg      <= WAIT_DEFAULT;
        end
        else
        begin
            st_s1_reg  <= {cpu_status_bit2, cpu_status_bit1, cpu_status_bit0};
            st_s2_reg  <= st_s1_reg;
            st_s3_reg  <= st_s2_reg;
            a_s1_reg   <= cpu_addr_in;
            a_s2_reg   <= a_s1_reg;
            a_s3_reg   <= a_s2_reg;
            bhe_s1_reg <= upper_byte_enable_n;
            bhe_s2_reg <= bhe_s1_reg;
            bhe_s3_reg <= bhe_s2_reg;
            j_s1_reg   <= wait_select_in;
            j_s2_reg   <= j_s1_reg;
            j_s3_reg   <= j_s2_reg;
            if (st_s2_reg == st_s3_reg)
                st_reg <= st_s3_reg;
            if (a_s2_reg == a_s3_reg)
                a_reg <= a_s3_reg;
            if (bhe_s2_reg == bhe_s3_reg)
                bhe_reg <= bhe_s3_reg;
            if (j_s2_reg == j_s3_reg)
                j_reg <= j_s3_reg;
        end
    end

    // --------------------------------------------------
    // 8MHz system clock, divide by three
    // --------------------------------------------------
    logic [1:0] ph_cnt;
    logic       sys_tick;

    dbcrc_div #(.WIDTH(2)) u_xdiv
    (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .en_in    (1'b1),
        .last_in  (DIV_LAST),
        .count_out(ph_cnt),
        .tick_out (sys_tick)
    );

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sys_clk_out          <= 1'b0;
            delayed_system_clock <= 1'b0;
        end
        else
        begin
            sys_clk_out          <= (ph_cnt == DIV_LAST);
            delayed_system_clock <= sys_clk_out;
        end
    end

    // --------------------------------------------------
    // bus state tracking and address latch strobe
    // --------------------------------------------------
    logic        cyc_start;
    logic        bus_active_reg;
    logic [19:0] lat_addr_reg;
    logic        lat_bhe_reg;
    logic [2:0]  lat_st_reg;
    logic        is_ram;
    logic        is_mem;
    logic [1:0]  wait_cnt_reg;
    logic        ram_wait;

    assign cyc_start = sys_tick && !bus_active_reg && (st_reg != ST_PASSIVE);
    assign is_mem    = (lat_st_reg == ST_CODE) || (lat_st_reg == ST_MRD) || (lat_st_reg == ST_MWR);
    assign is_ram    = is_mem && (lat_addr_reg[19:18] == 2'h0);

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            bus_active_reg   <= 1'b0;
            ale_out          <= 1'b1;
            first_bus_state  <= 1'b0;
            second_bus_state <= 1'b0;
            lat_addr_reg     <= '0;
            lat_bhe_reg      <= 1'b1;
            lat_st_reg       <= ST_PASSIVE;
        end
        else if (sys_tick)
        begin
            first_bus_state  <= cyc_start;
            second_bus_state <= first_bus_state;
            ale_out          <= !cyc_start;
            if (cyc_start)
            begin
                bus_active_reg <= 1'b1;
                lat_addr_reg   <= a_reg;
                lat_bhe_reg    <= bhe_reg;
                lat_st_reg     <= st_reg;
            end
            else if (bus_active_reg && st_reg == ST_PASSIVE && !first_bus_state && ready_out)
                bus_active_reg <= 1'b0;
        end
    end

    // command strobes from latched status, from second bus state
    logic cmd_en_reg;
    logic cmd_en_next;

    assign cmd_en_next = sys_tick ? (first_bus_state || (cmd_en_reg && bus_active_reg && st_reg != ST_PASSIVE))
                                  : cmd_en_reg;

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            cmd_en_reg <= 1'b0;
        else
            cmd_en_reg <= cmd_en_next;
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            mem_rd_n_out <= 1'b1;
            mem_wr_n_out <= 1'b1;
            io_rd_n_out  <= 1'b1;
            io_wr_n_out  <= 1'b1;
        end
        else
        begin
            mem_rd_n_out <= !(cmd_en_next && (lat_st_reg == ST_MRD || lat_st_reg == ST_CODE));
            mem_wr_n_out <= !(cmd_en_next && lat_st_reg == ST_MWR);
            io_rd_n_out  <= !(cmd_en_next && lat_st_reg == ST_IORD);
            io_wr_n_out  <= !(cmd_en_next && lat_st_reg == ST_IOWR);
        end
    end

    // --------------------------------------------------
    // wait states for non-ram cycles
    // --------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            wait_cnt_reg <= 2'h0;
        else if (sys_tick)
        begin
            if (first_bus_state && !is_ram)
                wait_cnt_reg <= (j_reg == 2'h0) ? WAIT_DEFAULT : j_reg;
            else if (wait_cnt_reg != 2'h0)
                wait_cnt_reg <= wait_cnt_reg - 2'h1;
        end
    end

    assign ready_out = (wait_cnt_reg == 2'h0) && !ram_wait;

    // --------------------------------------------------
    // refresh request and address counter
    // --------------------------------------------------
    logic       ref_tick;
    logic       ref_pend_reg;
    logic       ref_grant_reg;
    logic [7:0] ref_addr_reg;
    dbcrc_mem_e mem_state_reg;
    logic [1:0] phase_cnt_reg;
    logic       ram_pend_reg;
    logic       strobes_idle;

    dbcrc_div #(.WIDTH(7)) u_rdiv
    (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .en_in    (sys_tick),
        .last_in  (REFRESH_LAST),
        .count_out(),
        .tick_out (ref_tick)
    );

    assign strobes_idle = (mem_state_reg == ST_IDLE);

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ref_pend_reg <= 1'b0;
            ref_addr_reg <= REFRESH_RESET;
        end
        else
        begin
            if (ref_tick)
                ref_addr_reg <= ref_addr_reg + 8'h01;
            if (ref_tick)
                ref_pend_reg <= 1'b1;
            else if (sys_tick && strobes_idle)
                ref_pend_reg <= 1'b0;
        end
    end

    // --------------------------------------------------
    // row and column strobe sequencer
    // --------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            mem_state_reg <= ST_IDLE;
            ref_grant_reg <= 1'b0;
            ram_pend_reg  <= 1'b0;
        end
        else if (sys_tick)
        begin
            if (cyc_start && st_reg != ST_PASSIVE && (st_reg == ST_CODE || st_reg == ST_MRD || st_reg == ST_MWR)
                && a_reg[19:18] == 2'h0)
                ram_pend_reg <= 1'b1;
            unique case (mem_state_reg)
                ST_IDLE:
                begin
                    ref_grant_reg <= 1'b0;
                    if (ref_pend_reg)
                    begin
                        ref_grant_reg <= 1'b1;
                        mem_state_reg <= ST_ROW;
                    end
                    else if (ram_pend_reg)
                    begin
                        ram_pend_reg  <= 1'b0;
                        mem_state_reg <= ST_ROW;
                    end
                end
                ST_ROW:  mem_state_reg <= ST_BOTH;
                ST_BOTH: mem_state_reg <= ST_COL;
                ST_COL:  mem_state_reg <= ST_IDLE;
                ST_DONE: mem_state_reg <= ST_IDLE;
            endcase
        end
    end

    assign ram_wait = ram_pend_reg && cmd_en_reg;

    // --------------------------------------------------
    // dram pin drive
    // --------------------------------------------------
    logic row_on;
    logic col_on;
    logic col_sel;

    assign row_on  = (mem_state_reg == ST_ROW) || (mem_state_reg == ST_BOTH);
    assign col_on  = (mem_state_reg == ST_BOTH) || (mem_state_reg == ST_COL);
    assign col_sel = col_on || (row_on && !(row_strobe_lower_bank && row_strobe_upper_bank));

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            row_strobe_lower_bank <= 1'b1;
            row_strobe_upper_bank <= 1'b1;
            col_strobe_high_n_out <= 1'b1;
            col_strobe_low_n_out  <= 1'b1;
            mux_col_out           <= 1'b0;
            refresh_out           <= 1'b0;
            dram_addr_out         <= '0;
        end
        else
        begin
            refresh_out <= ref_grant_reg;
            if (ref_grant_reg)
            begin
                row_strobe_lower_bank <= !row_on;
                row_strobe_upper_bank <= !row_on;
                col_strobe_high_n_out <= 1'b1;
                col_strobe_low_n_out  <= 1'b1;
                mux_col_out           <= 1'b1;
                dram_addr_out         <= ref_addr_reg;
            end
            else
            begin
                row_strobe_lower_bank <= !(row_on && !lat_addr_reg[BANK_BIT]);
                row_strobe_upper_bank <= !(row_on && lat_addr_reg[BANK_BIT]);
                col_strobe_high_n_out <= !(col_on && !lat_bhe_reg);
                col_strobe_low_n_out  <= !(col_on && !lat_addr_reg[0]);
                mux_col_out           <= col_sel;
                dram_addr_out         <= col_sel ? lat_addr_reg[16:9] : lat_addr_reg[8:1];
            end
        end
    end
endmodule : dbcrc_ctrl

//--- testbench/dbcrc_ctrl_properties.sv
// port assertions for the bus cycle and dram controller
`timescale 1ns/1ps
module dbcrc_ctrl_properties
    import dbcrc_pkg::*;
(
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // watched outputs
    input  wire logic sys_clk_out,
    input  wire logic ale_out,
    input  wire logic mem_rd_n_out,
    input  wire logic mem_wr_n_out,
    input  wire logic io_rd_n_out,
    input  wire logic io_wr_n_out,
    input  wire logic ready_out,
    input  wire logic row_strobe_lower_bank,
    input  wire logic row_strobe_upper_bank,
    input  wire logic col_strobe_high_n_out,
    input  wire logic col_strobe_low_n_out,
    input  wire logic mux_col_out,
    input  wire logic refresh_out
);
    // ----------------------------------------
    // helper logic
    // ----------------------------------------
    localparam int GAP_MIN = 360;
    localparam int GAP_MAX = 408;
    logic       row_n;
    logic       col_n;
    logic       cmd_n;
    logic [9:0] gap_reg;
    logic       seen_reg;
    assign row_n = row_strobe_lower_bank & row_strobe_upper_bank;
    assign col_n = col_strobe_high_n_out & col_strobe_low_n_out;
    assign cmd_n = mem_rd_n_out & mem_wr_n_out & io_rd_n_out & io_wr_n_out;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // cycles between refresh grants
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            gap_reg  <= 10'h000;
            seen_reg <= 1'b0;
        end
        else if ($rose(refresh_out))
        begin
            gap_reg  <= 10'h001;
            seen_reg <= 1'b1;
        end
        else if (gap_reg != 10'h3FF)
        begin
            gap_reg <= gap_reg + 10'h001;
        end
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    chk_sys_clk_duty: assert property (
        $rose(sys_clk_out) |=> !sys_clk_out [*2] ##1 sys_clk_out) else $error("system clock not one third high");
    chk_ale_pulse: assert property (
        $fell(ale_out) |=> !ale_out [*2] ##1 ale_out) else $error("ale low not one system cycle");
    chk_cmd_after_ale: assert property (
        $fell(cmd_n) |-> $rose(ale_out)) else $error("command not at start of second state");
    chk_row_length: assert property (
        $fell(row_n) |-> !row_n [*6] ##1 row_n) else $error("row strobe length wrong");
    chk_col_follows: assert property (
        $fell(row_n) |-> ##3 (refresh_out || !col_n)) else $error("column strobe not one cycle after row");
    chk_mux_on_row: assert property (
        $fell(row_n) |-> ##[0:3] mux_col_out) else $error("mux not switched to column");
    chk_grant_idle: assert property (
        $rose(refresh_out) |-> $past(row_n) && $past(col_n)) else $error("refresh granted with strobes busy");
    chk_refresh_col_gated: assert property (
        refresh_out |-> col_n) else $error("column strobe reached memory in refresh");
    chk_refresh_mux_high: assert property (
        refresh_out && !row_n && $past(row_n) == 1'b0 |-> mux_col_out) else $error("mux low during refresh");
    chk_refresh_period: assert property (
        $rose(refresh_out) && seen_reg |-> gap_reg inside {[GAP_MIN:GAP_MAX]}) else $error("refresh period wrong");
    cover property ($rose(refresh_out));
    cover property ($fell(io_rd_n_out));
    cover property ($fell(row_strobe_upper_bank) && !refresh_out);
    cover property (refresh_out && !ready_out);
endmodule : dbcrc_ctrl_properties

bind dbcrc_ctrl dbcrc_ctrl_properties dbcrc_ctrl_properties_inst (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .sys_clk_out(sys_clk_out), .ale_out(ale_out),
    .mem_rd_n_out(mem_rd_n_out), .mem_wr_n_out(mem_wr_n_out), .io_rd_n_out(io_rd_n_out),
    .io_wr_n_out(io_wr_n_out), .ready_out(ready_out), .row_strobe_lower_bank(row_strobe_lower_bank),
    .row_strobe_upper_bank(row_strobe_upper_bank), .col_strobe_high_n_out(col_strobe_high_n_out),
    .col_strobe_low_n_out(col_strobe_low_n_out), .mux_col_out(mux_col_out), .refresh_out(refresh_out));

//--- testbench/dbcrc_cpu_model.sv
// processor and dram array model for the controller bench
`timescale 1ns/1ps
module dbcrc_cpu_model
    import dbcrc_pkg::*;
(
    // clock and controller outputs
    input  wire logic        clk_in,
    input  wire logic        ready_in,
    input  wire logic        ale_in,
    input  wire logic        refresh_in,
    input  wire logic [7:0]  dram_addr_in,
    input  wire logic [3:0]  strobe_n_in,
    // processor pins
    output logic      [19:0] cpu_addr_out,
    output logic             bhe_n_out,
    output logic      [2:0]  status_out
);
    int          waits;
    int          ref_cnt;
    logic [7:0]  row_cap;
    logic [7:0]  col_cap;
    logic [7:0]  ref_addr;
    logic [1:0]  bank_seen;
    logic [1:0]  lane_seen;
    logic        ref_hit;
    initial
    begin
        cpu_addr_out = 20'h0_0000;
        bhe_n_out    = 1'b1;
        status_out   = ST_PASSIVE;
        waits = 0;
        ref_cnt = 0;
        bank_seen = 2'b00;
        lane_seen = 2'b00;
        ref_hit = 1'b0;
    end
    // dram side: latch what the array would see
    always @(negedge clk_in)
    begin
        if (refresh_in && !(&strobe_n_in[3:2]) && !ref_hit)
        begin
            ref_addr = dram_addr_in;
            ref_cnt  = ref_cnt + 1;
        end
        ref_hit = refresh_in && !(&strobe_n_in[3:2]);
        if (!refresh_in)
        begin
            if (!(&strobe_n_in[3:2]) && bank_seen == 2'b00) row_cap = dram_addr_in;
            if (!(&strobe_n_in[1:0]) && lane_seen == 2'b00) col_cap = dram_addr_in;
            bank_seen = bank_seen | ~strobe_n_in[3:2];
            lane_seen = lane_seen | ~strobe_n_in[1:0];
        end
    end
    // one bus cycle: status held until the window closes, ready counted
    task automatic run_cycle(input logic [2:0] code, input logic [19:0] addr, input logic bhe_n);
        int n;
        @(posedge clk_in);
        #2;
        bank_seen = 2'b00;
        lane_seen = 2'b00;
        waits = 0;
        cpu_addr_out = addr;
        bhe_n_out = bhe_n;
        status_out = code;
        n = 0;
        while (ale_in && n < 40)
        begin
            @(posedge clk_in);
            #1;
            n++;
        end
        for (n = 0; n < 45; n++)
        begin
            @(posedge clk_in);
            #1;
            if (ready_in !== 1'b1) waits++;
        end
        #1;
        status_out = ST_PASSIVE;
        repeat (12) @(posedge clk_in);
        #2;
    endtask : run_cycle
endmodule : dbcrc_cpu_model

//--- testbench/test_dbcrc_ctrl.sv
// self-checking bench for the bus cycle and dram controller
`timescale 1ns/1ps
module test_dbcrc_ctrl
    import dbcrc_pkg::*;
;
    logic        clk_in, rst_n_in, upper_byte_enable_n, sys_clk_out, delayed_system_clock, ale_out;
    logic        cpu_status_bit0, cpu_status_bit1, cpu_status_bit2, first_bus_state, second_bus_state;
    logic        mem_rd_n_out, mem_wr_n_out, io_rd_n_out, io_wr_n_out, ready_out, mux_col_out, refresh_out;
    logic        row_strobe_lower_bank, row_strobe_upper_bank, col_strobe_high_n_out, col_strobe_low_n_out;
    logic [19:0] cpu_addr_in;
    logic [1:0]  wait_select_in;
    logic [7:0]  dram_addr_out;
    logic [2:0]  kinds [3];
    logic [31:0] lfsr_reg;
    logic [19:0] a;
    logic        b;
    int          miscompares, compares, cycles, i, j, k, c0, t0, prev;
    dbcrc_ctrl dbcrc_ctrl_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .cpu_addr_in(cpu_addr_in),
        .upper_byte_enable_n(upper_byte_enable_n), .cpu_status_bit0(cpu_status_bit0),
        .cpu_status_bit1(cpu_status_bit1), .cpu_status_bit2(cpu_status_bit2), .wait_select_in(wait_select_in),
        .sys_clk_out(sys_clk_out), .delayed_system_clock(delayed_system_clock), .ale_out(ale_out),
        .first_bus_state(first_bus_state), .second_bus_state(second_bus_state), .mem_rd_n_out(mem_rd_n_out),
        .mem_wr_n_out(mem_wr_n_out), .io_rd_n_out(io_rd_n_out), .io_wr_n_out(io_wr_n_out),
        .ready_out(ready_out), .dram_addr_out(dram_addr_out), .row_strobe_lower_bank(row_strobe_lower_bank),
        .row_strobe_upper_bank(row_strobe_upper_bank), .col_strobe_high_n_out(col_strobe_high_n_out),
        .col_strobe_low_n_out(col_strobe_low_n_out), .mux_col_out(mux_col_out), .refresh_out(refresh_out));
    dbcrc_cpu_model dbcrc_cpu_model_inst (.clk_in(clk_in), .ready_in(ready_out), .ale_in(ale_out),
        .refresh_in(refresh_out), .dram_addr_in(dram_addr_out),
        .strobe_n_in({row_strobe_upper_bank, row_strobe_lower_bank, col_strobe_high_n_out, col_strobe_low_n_out}),
        .cpu_addr_out(cpu_addr_in), .bhe_n_out(upper_byte_enable_n),
        .status_out({cpu_status_bit2, cpu_status_bit1, cpu_status_bit0}));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], 1'b0} ^ (v[31] ? 32'h0020_0007 : 32'h0000_0000);
    endfunction : lfsr_next
    function automatic int exp_waits(input int jumper);
        return (jumper == 0) ? 2 : jumper;
    endfunction : exp_waits
    task automatic step;
        @(posedge clk_in);
        #2;
    endtask : step
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want)
        begin
            miscompares++;
            $display("unexpected at %0t: seen 0x%0h expected 0x%0h", $time, seen, want);
        end
    endtask : check
    task automatic wrap_up;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up
    task automatic wait_refresh;
        int n;
        n = prev;
        prev = dbcrc_cpu_model_inst.ref_cnt;
        for (n = 0; n < 1000 && dbcrc_cpu_model_inst.ref_cnt == prev; n++) step();
        for (n = 0; n < 1000 && refresh_out !== 1'b0; n++) step();
        prev = dbcrc_cpu_model_inst.ref_cnt;
    endtask : wait_refresh
    // random ram cycle with lane and bank checks
    task automatic ram_cycle(input logic chk_wait);
        lfsr_reg = lfsr_next(lfsr_reg);
        a = {2'b00, lfsr_reg[17:0]};
        b = lfsr_reg[18] & ~a[0];
        dbcrc_cpu_model_inst.run_cycle(kinds[lfsr_reg[20:19] % 3], a, b);
        if (chk_wait) check((dbcrc_cpu_model_inst.waits + 2) / 3, 0);
        check(dbcrc_cpu_model_inst.bank_seen, a[17] ? 2'b10 : 2'b01);
        check(dbcrc_cpu_model_inst.lane_seen, {~b, ~a[0]});
        check(dbcrc_cpu_model_inst.row_cap, a[8:1]);
        check(dbcrc_cpu_model_inst.col_cap, a[16:9]);
    endtask : ram_cycle
    initial
    begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            wrap_up();
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        rst_n_in = 1'b0;
        wait_select_in = 2'h0;
        lfsr_reg = 32'd99739;
        kinds = '{ST_MRD, ST_MWR, ST_CODE};
        repeat (16) step();
        rst_n_in = 1'b1;
        repeat (4) step();
        check({ale_out, row_strobe_lower_bank, row_strobe_upper_bank, col_strobe_high_n_out}, 4'hF);
        check({mux_col_out, ready_out}, 2'b01);
        $display("test reset done");
        for (j = 0; j < 4; j++)
        begin
            for (k = 0; k < 3; k++)
            begin
                wait_select_in = j[1:0];
                lfsr_reg = lfsr_next(lfsr_reg);
                a = (k == 2) ? {2'b10, lfsr_reg[17:0]} : {4'h0, lfsr_reg[15:0]};
                dbcrc_cpu_model_inst.run_cycle(k == 0 ? ST_IORD : k == 1 ? ST_IOWR : ST_MRD, a, 1'b0);
                check((dbcrc_cpu_model_inst.waits + 2) / 3, exp_waits(j));
            end
        end
        $display("test wait states done");
        wait_refresh();
        for (i = 0; i < 24; i++)
        begin
            if (i % 4 == 0)
            begin
                t0 = dbcrc_cpu_model_inst.ref_addr;
                wait_refresh();
                if (i > 0) check(dbcrc_cpu_model_inst.ref_addr, 8'(t0 + 1));
            end
            ram_cycle(1'b1);
        end
        $display("test ram cycles done");
        for (i = 0; i < 3; i++)
        begin
            k = dbcrc_cpu_model_inst.ref_cnt;
            for (j = 0; j < 1000 && dbcrc_cpu_model_inst.ref_cnt == k; j++) step();
            repeat (377) step();
            ram_cycle(1'b0);
            check(dbcrc_cpu_model_inst.waits > 0, 1);
        end
        $display("test held cycle done");
        c0 = dbcrc_cpu_model_inst.ref_cnt;
        t0 = cycles;
        for (i = 0; i < 16; i++) ram_cycle(1'b0);
        check(dbcrc_cpu_model_inst.ref_cnt - c0 + 1 >= (cycles - t0) / 384, 1);
        $display("test refresh pending done");
        wrap_up();
    end
endmodule : test_dbcrc_ctrl
